// >>> err_mon_defs.svh
// Offsets, field positions, reset values and widths for the link error monitor.
// Assumes inclusion by bare name from files that need the register map.
`ifndef ERR_MON_DEFS_SVH
`define ERR_MON_DEFS_SVH

// Register byte offsets on the AHB-Lite bus
`define OFS_LINK_SEL      12'h000
`define OFS_FLAGS         12'h004
`define OFS_HDR_COUNT     12'h008
`define OFS_STREAM_COUNT  12'h00c
`define OFS_IRQ_STATUS    12'h010
`define OFS_IRQ_ENABLE    12'h014
`define OFS_IRQ_CLEAR     12'h018

// Flag register field positions
`define FLD_LINKTEST_COR  0
`define FLD_HEARTBEAT_COR 1
`define FLD_TRIG_UNC      2
`define FLD_TRIG_ACK_UNC  3
`define FLD_STREAM_UNC    4
`define FLD_CTRL_ACK_UNC  5

// Interrupt status positions
`define IRQ_FLAG_SET      0
`define IRQ_HDR_OVF       1
`define IRQ_FIX_WRAP      2
`define IRQ_BITS          3

// Counter widths and reset values
`define CNT_BITS          12
`define CNT_RESET         12'h000
`define SEL_RESET         2'h0

`endif

// >>> err_mon_pkg.sv
// Types shared by the link error monitor.
// Assumes no other package.
package err_mon_pkg;

    // Bus slave state, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b01,
        BUS_WRITE = 2'b10
    } bus_state_type;

    // Flags of one link
    typedef logic [5:0] flag_vec_type;

endpackage

// >>> sat_counter.sv
// Counter with overflow sticky bit, one per statistic.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "err_mon_defs.svh"

module sat_counter #(
    parameter int WIDTH = `CNT_BITS
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             inc,
    output logic [WIDTH-1:0]      count,
    output logic                  overflow,
    output logic                  wrap
);

    // Wrap pulse when the count passes its maximum
    assign wrap = inc && (count == {WIDTH{1'b1}});

    // Count up, wrapping round, until reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (inc) begin
            count <= count + 1'b1;
        end
    end

    // Overflow stays set once the count wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow <= 1'b0;
        end else if (wrap) begin
            overflow <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// >>> err_mon.sv
// Packet error statistics for four receive links, read over AHB-Lite.
// Assumes one clock, error pulses synchronous to it, a single AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "err_mon_defs.svh"

module err_mon
    import err_mon_pkg::*;
#(
    parameter int LINKS = 4,
    parameter int SELW  = 2
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [11:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Error event pulses, one bit per link; the stream byte fix is one bit for all links
    input  wire logic [LINKS-1:0] linktest_fixed,
    input  wire logic [LINKS-1:0] heartbeat_fixed,
    input  wire logic [LINKS-1:0] hdr_trl_uncorrectable,
    input  wire logic [LINKS-1:0] trig_uncorrectable,
    input  wire logic [LINKS-1:0] trig_ack_uncorrectable,
    input  wire logic [LINKS-1:0] stream_uncorrectable,
    input  wire logic [LINKS-1:0] ctrl_ack_uncorrectable,
    input  wire logic             stream_byte_fixed,
    // Interrupt
    output logic                  irq
);

    // Register map, one aligned 32-bit word each
    //
    // Link selector at offset 0x000
    //   Bits 1:0 pick the link for all per-link reads
    //   Read back as written, upper bits read 0
    //   Resets to link 0
    //
    // Flags of the selected link at offset 0x004
    //   Bit 0: link test packet error corrected
    //   Bit 1: heartbeat packet error corrected
    //   Bit 2: trigger packet error not corrected
    //   Bit 3: trigger ack packet error not corrected
    //   Bit 4: stream packet error not corrected
    //   Bit 5: control ack packet error not corrected
    //   Bits 31:6 read 0
    //   Read-only; writes are dropped
    //
    // Header/trailer count of the selected link at 0x008
    //   Bits 11:0: uncorrected error count
    //   Bit 12: overflow, set once the count wraps
    //   Bits 31:13 read 0
    //   Read-only; writes are dropped
    //
    // Stream single-byte fix count at offset 0x00c
    //   Bits 11:0: count, shared by all links
    //   Wraps to 0 after 4095, no readable overflow
    //   Read-only; writes are dropped
    //
    // Interrupt status at offset 0x010
    //   Bit 0: any flag event on any link
    //   Bit 1: any header/trailer counter wrapped
    //   Bit 2: stream fix counter wrapped
    //   Sticky; cleared only through the clear word
    //   Writes to this word are dropped
    //
    // Interrupt enable at offset 0x014
    //   Same layout as the status word
    //   Read and write
    //
    // Interrupt clear at offset 0x018
    //   Write one to clear the matching status bit
    //   Reads 0
    //
    // Every other offset reads 0 and ignores writes

    // Bus timing
    //
    // No wait states; ready out is tied high
    // Response is always OKAY
    // Address phase taken when selected, ready and active
    // Read data is captured at the address phase edge
    // The master then takes it at the next edge
    // Read data holds until the next read is taken
    // Write address is latched at the address phase
    // Write data is applied at the data phase edge
    // A read right after a write sees the old value
    // because the mux is sampled at the edge that writes the register
    // Back-to-back writes keep the data-phase state
    // Transfer size is ignored; words only

    // Event inputs
    //
    // Each input is a one-cycle pulse per link, except the shared stream byte fix
    // A pulse sets its flag at the next edge
    // Pulses may come back to back
    // Each high cycle counts once
    // Flags and counts hold until reset
    // Reading never clears a flag or a count
    // so software may poll without losing history

    // Counters
    //
    // Header/trailer counters are one per link
    // Each is 12 bits with a sticky overflow bit
    // The overflow bit makes the value 13 bits wide
    // After a wrap the low bits count on from 0
    // Software cannot tell how many wraps occurred
    // The stream fix counter is shared by all links
    // because the fix events are not per link

    // Interrupt behaviour
    //
    // Status bits collect events from all links
    // An event in the cycle of a clear wins
    // so no event is lost to a racing clear
    // The interrupt is a level, not a pulse
    // It stays high while an enabled bit is set
    // Masking a bit hides it but keeps its status
    // Enabling a set bit raises the line at once

    // Reset
    //
    // Asynchronous, active low
    // All flags, counts and status clear
    // Enable and selector clear
    // Read data clears to 0
    // The first transfer may start at the first edge
    // after release

    // Hazards
    //
    // The selector chooses the link at read time
    // A selector write and a read must not overlap
    // in one data phase, or the old link is read
    // The selector is only two bits wide
    // so higher written bits are ignored
    // Event pulses are assumed synchronous here
    // Asynchronous sources need synchronisers outside

    // Storage
    //
    flag_vec_type                 flags_r [LINKS];       // Sticky flags per link
    logic [`CNT_BITS-1:0]         hdr_count [LINKS];     // Header/trailer counts
    logic [LINKS-1:0]             hdr_ovf;               // Overflow bits
    logic [LINKS-1:0]             hdr_wrap;              // Overflow pulses
    logic [`CNT_BITS-1:0]         fix_count;             // Stream fix count
    logic                         fix_ovf;               // Stream fix overflow
    logic                         fix_wrap;              // Stream fix wrap pulse
    logic [SELW-1:0]              link_index_select_r;   // Link selector
    logic [`IRQ_BITS-1:0]         irq_status_r;          // Sticky event bits
    logic [`IRQ_BITS-1:0]         irq_enable_r;          // Interrupt mask
    logic [`IRQ_BITS-1:0]         irq_event;             // Events this cycle
    bus_state_type                bus_state_r;           // Data-phase state
    logic [11:0]                  waddr_r;               // Latched write address
    logic                         take;                  // Address phase accepted
    logic [31:0]                  rdata_nxt;             // Read mux
    logic                         any_flag_set;          // Any new flag event

    // Per-link flag setting; flags never clear except by reset
    generate
        for (genvar i = 0; i < LINKS; i++) begin : g_link
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags_r[i] <= '0;
                end else begin
                    // Each flag is sticky until reset
                    if (linktest_fixed[i])         flags_r[i][`FLD_LINKTEST_COR]  <= 1'b1;
                    if (heartbeat_fixed[i])        flags_r[i][`FLD_HEARTBEAT_COR] <= 1'b1;
                    if (trig_uncorrectable[i])     flags_r[i][`FLD_TRIG_UNC]      <= 1'b1;
                    if (trig_ack_uncorrectable[i]) flags_r[i][`FLD_TRIG_ACK_UNC]  <= 1'b1;
                    if (stream_uncorrectable[i])   flags_r[i][`FLD_STREAM_UNC]    <= 1'b1;
                    if (ctrl_ack_uncorrectable[i]) flags_r[i][`FLD_CTRL_ACK_UNC]  <= 1'b1;
                end
            end

            // Uncorrected header/trailer counter with overflow bit
            sat_counter #(
                .WIDTH    (`CNT_BITS)
            ) u_hdr_cnt (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .inc      (hdr_trl_uncorrectable[i]),
                .count    (hdr_count[i]),
                .overflow (hdr_ovf[i]),
                .wrap     (hdr_wrap[i])
            );
        end
    endgenerate

    // Single-byte fix counter for stream packets, shared by all links
    sat_counter #(
        .WIDTH    (`CNT_BITS)
    ) u_fix_cnt (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .inc      (stream_byte_fixed),
        .count    (fix_count),
        .overflow (fix_ovf),
        .wrap     (fix_wrap)
    );

    // Events that raise interrupt status
    assign any_flag_set = |{linktest_fixed, heartbeat_fixed, trig_uncorrectable,
                            trig_ack_uncorrectable, stream_uncorrectable, ctrl_ack_uncorrectable};
    always_comb begin
        irq_event                = '0;
        irq_event[`IRQ_FLAG_SET] = any_flag_set;
        irq_event[`IRQ_HDR_OVF]  = |hdr_wrap;
        irq_event[`IRQ_FIX_WRAP] = fix_wrap;
    end

    // Bus address phase accepted
    assign take = hsel && hready && htrans[1];

    // Data-phase tracking: writes land one cycle after their address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state_r <= BUS_IDLE;
            waddr_r     <= 12'h000;
        end else begin
            case (bus_state_r)
                BUS_IDLE: begin
                    if (take && hwrite) begin
                        bus_state_r <= BUS_WRITE;
                        waddr_r     <= haddr;
                    end
                end
                BUS_WRITE: begin
                    // Back-to-back write keeps the state
                    if (take && hwrite) begin
                        waddr_r <= haddr;
                    end else begin
                        bus_state_r <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_state_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // Link selector register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_index_select_r <= `SEL_RESET;
        end else if (bus_state_r == BUS_WRITE && waddr_r == `OFS_LINK_SEL) begin
            link_index_select_r <= hwdata[SELW-1:0];
        end
    end

    // Interrupt enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable_r <= '0;
        end else if (bus_state_r == BUS_WRITE && waddr_r == `OFS_IRQ_ENABLE) begin
            irq_enable_r <= hwdata[`IRQ_BITS-1:0];
        end
    end

    // Sticky interrupt status; a new event wins over a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status_r <= '0;
        end else if (bus_state_r == BUS_WRITE && waddr_r == `OFS_IRQ_CLEAR) begin
            irq_status_r <= (irq_status_r & ~hwdata[`IRQ_BITS-1:0]) | irq_event;
        end else begin
            irq_status_r <= irq_status_r | irq_event;
        end
    end

    // Level interrupt while any enabled bit is set
    assign irq = |(irq_status_r & irq_enable_r);

    // Read multiplexer; selected link chooses per-link values
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (haddr)
            `OFS_LINK_SEL:     rdata_nxt[SELW-1:0] = link_index_select_r;
            `OFS_FLAGS:        rdata_nxt[5:0] = flags_r[link_index_select_r];
            `OFS_HDR_COUNT: begin
                rdata_nxt[`CNT_BITS-1:0] = hdr_count[link_index_select_r];
                rdata_nxt[`CNT_BITS]     = hdr_ovf[link_index_select_r];
            end
            `OFS_STREAM_COUNT: rdata_nxt[`CNT_BITS-1:0] = fix_count;
            `OFS_IRQ_STATUS:   rdata_nxt[`IRQ_BITS-1:0] = irq_status_r;
            `OFS_IRQ_ENABLE:   rdata_nxt[`IRQ_BITS-1:0] = irq_enable_r;
            default:           rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase, valid in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rdata_nxt;
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

endmodule
`default_nettype wire

// >>> err_mon_monitor.sv
// Checker on the error monitor's bus and interrupt ports.
// Assumes binding into err_mon; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module err_mon_monitor (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        irq
);
    logic ap;      // Transfer taken this edge
    logic wr_dp_r; // Write in data phase
    assign ap = hsel & hready & htrans[1];
    // Marks the data phase of every write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_dp_r <= 1'b0;
        else wr_dp_r <= ap & hwrite;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Read address phase at one offset
    sequence rd_at(logic [11:0] a);
        ap && !hwrite && haddr == a;
    endsequence
    ready_always_a: assert property (hreadyout) else $error("wait state seen");
    resp_okay_a: assert property (!hresp) else $error("error response seen");
    sel_read_a: assert property (rd_at(12'h000) |=> hrdata[31:2] == 30'h0)
        else $error("selector read too wide");
    flag_read_a: assert property (rd_at(12'h004) |=> hrdata[31:6] == 26'h0)
        else $error("flag read too wide");
    count_read_a: assert property (rd_at(12'h008) |=> hrdata[31:13] == 19'h0)
        else $error("count read too wide");
    fix_read_a: assert property (rd_at(12'h00c) |=> hrdata[31:12] == 20'h0)
        else $error("fix count read too wide");
    unmapped_zero_a: assert property (ap && !hwrite && haddr > 12'h014 |=> hrdata == 32'h0)
        else $error("empty offset read nonzero");
    rdata_hold_a: assert property (!(ap && !hwrite) |=> $stable(hrdata))
        else $error("read data moved unasked");
    irq_fall_a: assert property ($fell(irq) |-> $past(wr_dp_r))
        else $error("interrupt dropped without write");
endmodule
bind err_mon err_mon_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
`default_nettype wire

// >>> camera_model.sv
// Camera-side model: one error pulse per packet on the chosen kind and link.
// Assumes the bench raises go just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module camera_model (
    input  wire logic       go,
    input  wire logic [2:0] kind,
    input  wire logic [1:0] link,
    output logic [7:0][3:0] pkt_err
);
    // Kinds 0-5 flag events, 6 header/trailer uncorrected error, 7 stream byte fix
    always_comb begin
        pkt_err = '0;
        if (go) pkt_err[kind][link] = 1'b1;
    end
endmodule
`default_nettype wire

// >>> err_mon_tb.sv
// Bench: AHB-Lite reads and writes against camera error pulses.
// Assumes err_mon, its checker and camera_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module err_mon_tb;
    logic             hclk, hresetn, hsel, hwrite, go;
    logic [11:0]      haddr;
    logic [1:0]       htrans, link;
    logic [2:0]       hsize, kind;
    logic [31:0]      hwdata, q, e;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, irq;
    wire logic [7:0][3:0] pe;
    int               failures, num_checks;
    err_mon dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .linktest_fixed(pe[0]), .heartbeat_fixed(pe[1]),
        .trig_uncorrectable(pe[2]), .trig_ack_uncorrectable(pe[3]), .stream_uncorrectable(pe[4]),
        .ctrl_ack_uncorrectable(pe[5]), .hdr_trl_uncorrectable(pe[6]),
        .stream_byte_fixed(|pe[7]), .irq(irq));
    camera_model cam_u (.go(go), .kind(kind), .link(link), .pkt_err(pe));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One single transfer; read data lands in q
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // Back-to-back error pulses, then one quiet cycle
    task automatic ev(input logic [2:0] k, input logic [1:0] l, input int n);
        kind <= k;
        link <= l;
        go   <= 1'b1;
        repeat (n) @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Watchdog well past the 4.2k-cycle run
    initial begin
        #300us;
        failures++;
        final_report;
    end
    initial begin
        {hresetn, hsel, hwrite, go, haddr, htrans, link, kind, hwdata} = '0;
        hsize = 3'h2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd(12'h004, 32'h0);
        // Kind k on link k mod 4; flag bit k
        for (int k = 0; k < 6; k++) ev(k[2:0], k[1:0], 1);
        for (int l = 0; l < 4; l++) begin
            e = 32'h0;
            for (int k = l; k < 6; k += 4) e[k] = 1'b1;
            bus(1'b1, 12'h000, 32'(l));
            rd(12'h004, e);
        end
        ev(3'h6, 2'h2, 3);
        ev(3'h6, 2'h3, 4095);
        bus(1'b1, 12'h000, 32'h2);
        rd(12'h008, 32'h3);
        bus(1'b1, 12'h000, 32'h3);
        rd(12'h008, 32'hfff);
        ev(3'h6, 2'h3, 1);
        rd(12'h008, 32'h1000);
        ev(3'h6, 2'h3, 1);
        rd(12'h008, 32'h1001);
        bus(1'b1, 12'h000, 32'h1);
        rd(12'h008, 32'h0);
        rd(12'h000, 32'h1);
        ev(3'h7, 2'h2, 5);
        rd(12'h00c, 32'h5);
        // Interrupt: status, mask, clear, new event
        rd(12'h010, 32'h3);
        bus(1'b1, 12'h014, 32'h4);
        #1 chk({31'h0, irq}, 32'h0);
        bus(1'b1, 12'h014, 32'h3);
        #1 chk({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h010, 32'h0);
        rd(12'h010, 32'h3);
        bus(1'b1, 12'h018, 32'h3);
        #1 chk({31'h0, irq}, 32'h0);
        rd(12'h018, 32'h0);
        ev(3'h0, 2'h1, 1);
        #1 chk({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h004, 32'h0);
        rd(12'h004, 32'h23);
        rd(12'h020, 32'h0);
        // Reset in mid-run clears flags, counts and selector
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
